// ===== core/txwcs_buf2.v
// two-entry valid/ready buffer with full and empty flags
module txwcs_buf2 #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             full,
	output wire             empty
);
	// ==========================================
	// storage
	reg [WIDTH-1:0] mem_q [0:1];     // two words
	reg             wp_q;            // write pointer
	reg             rp_q;            // read pointer
	reg [1:0]       cnt_q;           // occupancy
	wire            wr_fire;
	wire            rd_fire;

	assign full      = (cnt_q == 2'h2);
	assign empty     = (cnt_q == 2'h0);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem_q[rp_q];
	assign wr_fire   = in_valid & ~full;
	assign rd_fire   = out_ready & ~empty;

	// pointer and count update
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (wr_fire)
				wp_q <= ~wp_q;
			if (rd_fire)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, wr_fire} - {1'b0, rd_fire};
		end
	end

	// data store, no reset needed
	always @(posedge clk) begin
		if (wr_fire)
			mem_q[wp_q] <= in_data;
	end
endmodule // txwcs_buf2

// ===== core/txwcs_defines.vh
// constants for the transmit fifo write clock select block
`ifndef TXWCS_DEFINES_VH
`define TXWCS_DEFINES_VH
// channels per transceiver block
`define TXWCS_CH_PER_BLK  4
// number of transceiver blocks
`define TXWCS_NUM_BLK     4
// configuration mode codes
`define TXWCS_MODE_W      2
`define TXWCS_MODE_NONB   2'h0
`define TXWCS_MODE_X4     2'h1
`define TXWCS_MODE_X8     2'h2
`define TXWCS_MODE_DIRECT 2'h3
// write clock source codes per channel
`define TXWCS_SRC_W       2
`define TXWCS_SRC_FWD_OWN 2'h0
`define TXWCS_SRC_FWD_CH0 2'h1
`define TXWCS_SRC_CORE    2'h2
`define TXWCS_SRC_USER    2'h3
// read clock source codes per channel
`define TXWCS_RD_LOCAL    2'h0
`define TXWCS_RD_CMU_LOC  2'h1
`define TXWCS_RD_CMU_MST  2'h2
// clock period in ns and fifo depth
`define TXWCS_CLK_NS      5
`define TXWCS_FIFO_DEPTH  2
`endif

// ===== core/txwcs_top.v
// transmit fifo write and read clock selection with data buffer
// How it works
// - bonded modes: write clock from core clock
// - non-bonded auto: share channel 0 forwarded clock
// - no forwarded clock sharing across blocks
// - user write-clock port overrides auto choice
// - non-bonded read clock local, halved with serializer
// - x4 read clock from local multiplier unit
// - x8 read clock from master multiplier unit
// - no core clock in direct mode
// - forward channel clock or core clock
`include "txwcs_defines.vh"
module txwcs_top #(
	parameter NUM_CH = `TXWCS_CH_PER_BLK * `TXWCS_NUM_BLK,
	parameter WIDTH  = 8
) (
	input  wire                           CLK,
	input  wire                           RST_N,
	input  wire [`TXWCS_MODE_W-1:0]       MODE,
	input  wire                           BYTE_SER_EN,
	input  wire [NUM_CH-1:0]              USER_WRCLK_EN,
	input  wire [NUM_CH-1:0]              IDENT_CH0,
	input  wire                           WR_VALID,
	output reg                            WR_READY,
	input  wire [WIDTH-1:0]               WR_DATA,
	output reg                            RD_VALID,
	input  wire                           RD_READY,
	output reg  [WIDTH-1:0]               RD_DATA,
	input  wire                           WR_PULSE,
	input  wire                           RD_PULSE,
	output reg  [NUM_CH*2-1:0]            WR_SRC,
	output reg  [NUM_CH*2-1:0]            RD_SRC,
	output reg  [NUM_CH-1:0]              RD_HALF,
	output reg  [NUM_CH-1:0]              FWD_CH_CLK_EN,
	output reg                            CORE_CLK_EN,
	output reg                            OVERFLOW,
	output reg                            UNDERRUN
);
	// ==========================================
	// reset release through two flops
	// assertion is immediate; release waits two edges so that every flop
	// leaves reset on the same edge
	reg  rst_s1_q;              // first stage, read only by second
	reg  rst_s2_q;              // released reset
	wire rst_n_i = rst_s2_q;    // internal reset

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// ==========================================
	// mode decode helpers
	function is_bonded;
		input [`TXWCS_MODE_W-1:0] m;
		begin
			is_bonded = (m == `TXWCS_MODE_X4) | (m == `TXWCS_MODE_X8);
		end
	endfunction

	// ==========================================
	// write source of one channel
	// the user port wins over every mode; otherwise bonded modes take the
	// core clock, direct mode keeps each channel on its own clock, and the
	// automatic choice shares channel 0's clock only inside one block
	function [`TXWCS_SRC_W-1:0] wr_sel;
		input                     user_en;   // channel's own write-clock port on
		input [`TXWCS_MODE_W-1:0] m;         // configuration mode
		input                     ident;     // channel matches its block's channel 0
		input                     not_first; // channel is not channel 0 of its block
		begin
			if (user_en)
				wr_sel = `TXWCS_SRC_USER;
			else if (is_bonded(m))
				wr_sel = `TXWCS_SRC_CORE;
			else if (m == `TXWCS_MODE_DIRECT)
				wr_sel = `TXWCS_SRC_FWD_OWN;
			else if (ident && not_first)
				wr_sel = `TXWCS_SRC_FWD_CH0;  // own block only
			else
				wr_sel = `TXWCS_SRC_FWD_OWN;  // distinct channel keeps its own clock
		end
	endfunction

	// ==========================================
	// read source of one channel
	// the mode alone picks it; halving for the byte serializer is a
	// separate flag so that every source is halved alike
	function [1:0] rd_sel;
		input [`TXWCS_MODE_W-1:0] m;  // configuration mode
		begin
			case (m)
				`TXWCS_MODE_X4: rd_sel = `TXWCS_RD_CMU_LOC;
				`TXWCS_MODE_X8: rd_sel = `TXWCS_RD_CMU_MST;
				default:        rd_sel = `TXWCS_RD_LOCAL;
			endcase
		end
	endfunction

	// ==========================================
	// per-channel clock source selection
	// each channel drives only its own slice, so every bit has one driver;
	// channel index modulo the block size finds the block's channel 0
	wire [NUM_CH*2-1:0] wr_src_d;  // next write source
	wire [NUM_CH*2-1:0] rd_src_d;  // next read source
	wire [NUM_CH-1:0]   fwd_en_d;  // next forward enables
	wire                bonded;    // x4 or x8 bonded mode
	assign bonded = is_bonded(MODE);
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
			// write source: user port first, then mode rules
			assign wr_src_d[g*2 +: 2] = wr_sel(USER_WRCLK_EN[g], MODE, IDENT_CH0[g],
				(g % `TXWCS_CH_PER_BLK) != 0);
			// read source by mode
			assign rd_src_d[g*2 +: 2] = rd_sel(MODE);
			// forwarded channel clock in non-bonded modes
			assign fwd_en_d[g] = ~bonded;
		end
	endgenerate

	// registered selection outputs
	// every selection output is a flop, so a mode change shows one
	// cycle later and never glitches the clock routing it stands for
	always @(posedge CLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			WR_SRC        <= {NUM_CH*2{1'b0}};
			RD_SRC        <= {NUM_CH*2{1'b0}};
			RD_HALF       <= {NUM_CH{1'b0}};
			FWD_CH_CLK_EN <= {NUM_CH{1'b0}};
			CORE_CLK_EN   <= 1'b0;
		end else begin
			WR_SRC        <= wr_src_d;
			RD_SRC        <= rd_src_d;
			RD_HALF       <= {NUM_CH{BYTE_SER_EN}};
			FWD_CH_CLK_EN <= fwd_en_d;
			// core clock only when bonded, never in direct
			CORE_CLK_EN   <= is_bonded(MODE);
		end
	end

	// ==========================================
	// phase compensation buffer
	// two words ride between the fabric writer and the transmit reader;
	// the output register adds a third slot, so a stalling reader
	// never costs a word
	wire             b_out_valid;
	wire             wr_take;      // word accepted at this edge
	wire             wr_full_next; // buffer will be full after this edge
	wire [WIDTH-1:0] b_out_data;
	wire             b_full;
	wire             b_empty;
	wire             take = RD_READY | ~RD_VALID;  // output stage can load
	assign wr_take      = WR_VALID & WR_READY;
	assign wr_full_next = ~b_empty & ~take & (b_full | wr_take);

	txwcs_buf2 #(
		.WIDTH(WIDTH)
	) u_buf (
		.clk       (CLK),
		.rst_n     (rst_n_i),
		.in_valid  (wr_take),
		.in_ready  (),
		.in_data   (WR_DATA),
		.out_valid (b_out_valid),
		.out_ready (take),
		.out_data  (b_out_data),
		.full      (b_full),
		.empty     (b_empty)
	);

	// output register stage and ready flop
	// the output word loads whenever it is empty or being taken, which
	// keeps RD_VALID and RD_DATA straight from flops
	always @(posedge CLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			RD_VALID <= 1'b0;
			RD_DATA  <= {WIDTH{1'b0}};
			WR_READY <= 1'b0;
		end else begin
			if (take) begin
				RD_VALID <= b_out_valid;
				if (b_out_valid)
					RD_DATA <= b_out_data;
			end
			// ready only when a slot stays free after this edge, so a word
			// offered under ready always lands and a stall loses nothing
			WR_READY <= ~wr_full_next;
		end
	end

	// ==========================================
	// sticky rate mismatch flags
	// only reset clears them; a flag seen high means the write and read
	// clocks drifted at some point since reset
	always @(posedge CLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			OVERFLOW <= 1'b0;
			UNDERRUN <= 1'b0;
		end else begin
			// write attempt while full
			// a held word under low ready is back-pressure, not a write
			if (WR_PULSE & b_full)
				OVERFLOW <= 1'b1;
			// read attempt while empty
			if (RD_PULSE & b_empty & ~RD_VALID)
				UNDERRUN <= 1'b1;
		end
	end
endmodule // txwcs_top

// ===== verification/tb.sv
// self-checking bench for the write clock select block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0, RST_N = 1'b0, BYTE_SER_EN = 1'b0, RD_READY = 1'b0, go = 1'b0;
	logic WR_PULSE = 1'b0, RD_PULSE = 1'b0;
	logic [1:0] MODE = 2'h0;
	logic [15:0] USER_WRCLK_EN = 16'h0000, IDENT_CH0 = 16'h0000;
	wire WR_VALID, WR_READY, RD_VALID, CORE_CLK_EN, OVERFLOW, UNDERRUN;
	wire [7:0] WR_DATA, RD_DATA;
	wire [31:0] WR_SRC, RD_SRC;
	wire [15:0] RD_HALF, FWD_CH_CLK_EN;
	int err_count = 0, n_tests = 0, nrx = 0;
	logic [7:0] exp_q = 8'h00; // next word expected out
	always #2.5 CLK = ~CLK;
	txwcs_top dut (.*);
	txwcs_fab u_fab (.clk(CLK), .go(go), .rdy(WR_READY), .vld(WR_VALID), .dat(WR_DATA));
	// ========
	task chk(string nm, logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e) begin err_count++; $display("[ERR] %s exp %h got %h", nm, e, s); end
	endtask
	task end_of_test;
		if (err_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task cyc(int n); repeat (n) @(posedge CLK); #1; endtask
	// every mode: enables, read source, halving
	task t_mode;
		for (int m = 0; m < 4; m++) begin
			@(posedge CLK); MODE <= m[1:0]; BYTE_SER_EN <= m[0];
			cyc(2);
			chk("core_en", CORE_CLK_EN, m == 1 || m == 2);
			chk("fwd_en", FWD_CH_CLK_EN, (m == 0 || m == 3) ? 16'hFFFF : 16'h0000);
			chk("rd_src", RD_SRC, {16{m == 1 ? 2'h1 : m == 2 ? 2'h2 : 2'h0}});
			chk("rd_half", RD_HALF, {16{m[0]}});
		end
	endtask
	// one write source setting
	task wsel(logic [1:0] m, logic [15:0] u, logic [15:0] id, logic [31:0] e);
		@(posedge CLK); MODE <= m; USER_WRCLK_EN <= u; IDENT_CH0 <= id;
		cyc(2);
		chk("wr_src", WR_SRC, e);
	endtask
	// stalling reader, words must come in counting order
	task rx(int n);
		for (int i = 0; i < n; i++) begin
			@(negedge CLK);
			if (RD_VALID && RD_READY) begin
				chk("rd_data", RD_DATA, exp_q);
				exp_q++;
				nrx++;
			end
			@(posedge CLK); RD_READY <= i[0];
		end
	endtask
	// stream with receiver stalls, no loss
	task t_stream;
		@(posedge CLK); go <= 1'b1;
		rx(30);
		go <= 1'b0;
		rx(30);
		chk("rx_count", nrx > 10, 1'b1);
		chk("no_loss", exp_q, u_fab.cnt_q);
		chk("underrun", UNDERRUN, 1'b0);
		chk("stall_ovf", OVERFLOW, 1'b0);
	endtask
	// fill until refused, then drain past empty
	task t_flags;
		@(posedge CLK); RD_READY <= 1'b0; go <= 1'b1;
		repeat (6) @(posedge CLK);
		WR_PULSE <= 1'b1; go <= 1'b0;
		@(posedge CLK); WR_PULSE <= 1'b0;
		cyc(2);
		chk("overflow", OVERFLOW, 1'b1);
		chk("wr_ready", WR_READY, 1'b0);
		rx(30);
		chk("no_loss", exp_q, u_fab.cnt_q);
		chk("underrun", UNDERRUN, 1'b0);
		@(posedge CLK); RD_PULSE <= 1'b1;
		@(posedge CLK); RD_PULSE <= 1'b0;
		cyc(3);
		chk("underrun", UNDERRUN, 1'b1);
		chk("ovf_sticky", OVERFLOW, 1'b1);
	endtask
	// hang guard
	initial begin #20us; err_count++; end_of_test; end
	// main sequence
	initial begin
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		cyc(3);
		t_mode;
		wsel(2'h1, 16'h0008, 16'h0000, 32'hAAAAAAEA);
		wsel(2'h2, 16'h0000, 16'h0000, 32'hAAAAAAAA);
		wsel(2'h0, 16'h0000, 16'hFFFF, 32'h54545454);
		wsel(2'h0, 16'h0000, 16'h0000, 32'h00000000);
		wsel(2'h3, 16'h0000, 16'hFFFF, 32'h00000000);
		wsel(2'h0, 16'hFFFF, 16'h0000, 32'hFFFFFFFF);
		t_stream;
		t_flags;
		end_of_test;
	end
endmodule // tb

// ===== verification/txwcs_asserts.sv
// checker on the top ports of the write clock select block
module txwcs_asserts #(parameter NUM_CH = 16, parameter WIDTH = 8) (
	input wire CLK, RST_N, BYTE_SER_EN, CORE_CLK_EN, OVERFLOW, UNDERRUN,
	input wire [1:0] MODE,
	input wire [NUM_CH-1:0] USER_WRCLK_EN, IDENT_CH0, RD_HALF, FWD_CH_CLK_EN,
	input wire [NUM_CH*2-1:0] WR_SRC, RD_SRC
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// settle count: checks start after five edges; outputs track inputs from the third
	logic [2:0] up_q;
	wire ok = up_q == 3'h5;
	always @(posedge CLK or negedge RST_N)
		if (!RST_N) up_q <= 3'h0;
		else if (!ok) up_q <= up_q + 3'h1;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_CORE_ON: assert property (ok && MODE[1]!=MODE[0] |=> CORE_CLK_EN)
		else $error("no core clock");
	AST_CORE_OFF: assert property (ok && MODE==2'h3 |=> !CORE_CLK_EN && &FWD_CH_CLK_EN)
		else $error("core clock in direct");
	AST_WR_CORE: assert property (ok && MODE==2'h2 && !USER_WRCLK_EN |=> WR_SRC=={NUM_CH{2'h2}})
		else $error("bonded write source");
	AST_USER: assert property (ok && USER_WRCLK_EN[3] |=> WR_SRC[7:6]==2'h3)
		else $error("user port ignored");
	AST_SHARE: assert property (ok && MODE==2'h0 && IDENT_CH0[5] && !USER_WRCLK_EN[5] |=> WR_SRC[11:10]==2'h1)
		else $error("no block share");
	AST_RD_X4: assert property (ok && MODE==2'h1 |=> RD_SRC=={NUM_CH{2'h1}})
		else $error("x4 read source");
	AST_RD_X8: assert property (ok && MODE==2'h2 |=> RD_SRC=={NUM_CH{2'h2}})
		else $error("x8 read source");
	AST_HALF: assert property (ok |=> RD_HALF=={NUM_CH{$past(BYTE_SER_EN)}})
		else $error("read halving");
	AST_STICKY: assert property (($past(OVERFLOW) |-> OVERFLOW) and ($past(UNDERRUN) |-> UNDERRUN))
		else $error("flag not sticky");
endmodule // txwcs_asserts
bind txwcs_top txwcs_asserts #(.NUM_CH(NUM_CH), .WIDTH(WIDTH)) u_chk (.*);

// ===== verification/txwcs_fab.sv
// fabric-side writer feeding the fifo write port
module txwcs_fab (
	input wire clk, go, rdy,
	output logic vld,
	output wire [7:0] dat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q; // next counting word
	initial begin vld = 1'b0; cnt_q = 8'h00; end
	// idle bus shows the inverse so stale data never passes
	assign dat = vld ? cnt_q : ~cnt_q;
	// one ungated pin clock shared with the read side and all channels
	always @(posedge clk)
		if (vld && rdy) begin
			vld <= go;
			cnt_q <= cnt_q + 8'h01;
		end else if (!vld) vld <= go;
endmodule // txwcs_fab
